// File: rtl/dac_map.vh
// Purpose: constants for the domain access checker
// Assumes: 32-bit addresses, 4-bit domain identifiers
// Notes: no software-reachable registers; configuration arrives on ports
`ifndef DAC_MAP_VH
`define DAC_MAP_VH

`define ADDR_W 32
`define DID_W 4
`define NUM_MASTERS 4
`define MID_W 2
`define NUM_REGIONS 4
`define NUM_PERIPHS 4
`define NUM_DOMAINS 4
`define NUM_SEMAS 4
`define POLICY_W 3
`define PERIPH_W 2
`define SEMA_W 2

// access levels, highest first
`define LVL_SEC_PRIV 2'h3
`define LVL_SEC_USER 2'h2
`define LVL_NS_PRIV 2'h1
`define LVL_NS_USER 2'h0

// master categories
`define CAT_CORE 1'h0
`define CAT_NONCORE 1'h1

// error status bits
`define ERR_VALID_BIT 0
`define ERR_WRITE_BIT 1
`define ERR_PRIV_BIT 2
`define ERR_SEC_BIT 3

`endif

// File: rtl/domain_access_checker.v
// Purpose: per-transaction domain access check in front of slaves
// Assumes: one request per cycle, configuration held stable by its owner
// Notes: decision and forward are registered, one cycle after the request
//
// Operation
// RQ1 - every transaction carries domain identifier, privilege and security; all three decide
// RQ2 - every access checked; allowed ones forwarded, others aborted with error recorded; code records only the first denial until err_clear
// RQ3 - four ordered levels from privilege and security attributes
// RQ4 - separate read and write permission decisions
// RQ5 - semaphore-gated targets accept writes only from the owning domain
// RQ6 - each domain policy per target is a three-bit level selection code
// RQ7 - masters without nonsecure privileged state use three levels only
// RQ8 - memory permissions from region descriptors, peripherals from access registers
// RQ9 - resources in four categories; each master maps to a unique domain
// RQ10 - security attribute taken from processor security-state signals
// RQ11 - violation latches address, domain, direction, attributes; bus error returned; code latches only the first violation until err_clear
`timescale 1ns/1ps
`include "dac_map.vh"

module domain_access_checker (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // request from the interconnect
   input wire req_valid,
   input wire [`MID_W-1:0] req_master,
   input wire [`ADDR_W-1:0] req_addr,
   input wire req_write,
   input wire req_priv,
   input wire req_nonsecure_state,
   input wire req_periph,
   input wire [`PERIPH_W-1:0] req_periph_index,
   // master to domain binding and category, flattened per master
   input wire [`NUM_MASTERS*`DID_W-1:0] master_domain_map,
   input wire [`NUM_MASTERS-1:0] master_category,
   input wire [`NUM_MASTERS-1:0] master_no_ns_priv,
   // region descriptors, flattened per region
   input wire [`NUM_REGIONS*`ADDR_W-1:0] region_start,
   input wire [`NUM_REGIONS*`ADDR_W-1:0] region_end,
   input wire [`NUM_REGIONS-1:0] region_valid,
   input wire [`NUM_REGIONS*`NUM_DOMAINS*`POLICY_W-1:0] region_rd_policy,
   input wire [`NUM_REGIONS*`NUM_DOMAINS*`POLICY_W-1:0] region_wr_policy,
   input wire [`NUM_REGIONS-1:0] region_sema_en,
   input wire [`NUM_REGIONS*`SEMA_W-1:0] region_sema_sel,
   // peripheral domain access control
   input wire [`NUM_PERIPHS*`NUM_DOMAINS*`POLICY_W-1:0] periph_rd_policy,
   input wire [`NUM_PERIPHS*`NUM_DOMAINS*`POLICY_W-1:0] periph_wr_policy,
   input wire [`NUM_PERIPHS-1:0] periph_sema_en,
   input wire [`NUM_PERIPHS*`SEMA_W-1:0] periph_sema_sel,
   // hardware semaphore owners
   input wire [`NUM_SEMAS-1:0] sema_locked,
   input wire [`NUM_SEMAS*`DID_W-1:0] sema_owner,
   // error capture control
   input wire err_clear,
   // forward to slave
   output reg fwd_valid,
   output reg [`ADDR_W-1:0] fwd_addr,
   output reg fwd_write,
   output reg fwd_periph,
   output reg [`DID_W-1:0] fwd_domain,
   // response to master
   output reg resp_error,
   output reg [`MID_W-1:0] resp_master,
   // captured error details
   output reg [3:0] err_status,
   output reg [`ADDR_W-1:0] err_addr,
   output reg [`DID_W-1:0] err_domain,
   output reg [`MID_W-1:0] err_master
);

   // ************************************************************
   // helper functions
   // ************************************************************

   // level from attributes, three-level fold for restricted masters
   function [1:0] access_level;
      input priv;
      input nonsecure;
      input no_ns_priv;
      begin
         if (!nonsecure && priv)
            access_level = `LVL_SEC_PRIV; // RQ3
         else if (!nonsecure)
            access_level = `LVL_SEC_USER; // RQ3
         else if (priv && !no_ns_priv)
            access_level = `LVL_NS_PRIV; // RQ3
         else
            access_level = `LVL_NS_USER; // RQ7
      end
   endfunction

   // three-bit code gives the lowest level admitted; 0 and above 4 deny
   // code 1: secure privileged only, 2: secure up, 3: ns priv up, 4: all
   function level_ok;
      input [`POLICY_W-1:0] code;
      input [1:0] lvl;
      begin
         case (code)
            3'h1: level_ok = (lvl == `LVL_SEC_PRIV); // RQ6
            3'h2: level_ok = (lvl >= `LVL_SEC_USER); // RQ6
            3'h3: level_ok = (lvl >= `LVL_NS_PRIV); // RQ6
            3'h4: level_ok = 1'b1; // RQ6
            default: level_ok = 1'b0;
         endcase
      end
   endfunction

   // one policy code out of a flattened target by domain table
   function [`POLICY_W-1:0] policy_pick;
      input [`NUM_REGIONS*`NUM_DOMAINS*`POLICY_W-1:0] policy_tab;
      input [1:0] target;
      input [1:0] didx;
      begin
         policy_pick = policy_tab[(target*`NUM_DOMAINS+didx)*`POLICY_W +: `POLICY_W]; // RQ6
      end
   endfunction

   // read and write rights come from separate tables
   function [`POLICY_W-1:0] policy_by_dir;
      input write;
      input [`NUM_REGIONS*`NUM_DOMAINS*`POLICY_W-1:0] rd_tab;
      input [`NUM_REGIONS*`NUM_DOMAINS*`POLICY_W-1:0] wr_tab;
      input [1:0] target;
      input [1:0] didx;
      begin
         if (write)
            policy_by_dir = policy_pick(wr_tab, target, didx); // RQ4
         else
            policy_by_dir = policy_pick(rd_tab, target, didx); // RQ4
      end
   endfunction

   // inclusive address window of one descriptor
   function region_match;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] lo;
      input [`ADDR_W-1:0] hi;
      input enabled;
      begin
         region_match = enabled && (addr >= lo) && (addr <= hi); // RQ8
      end
   endfunction

   // gated writes pass only for the locked owner
   function sema_pass;
      input gated;
      input write;
      input locked;
      input [`DID_W-1:0] owner;
      input [`DID_W-1:0] domain_identifier;
      begin
         sema_pass = !(write && gated) || (locked && (owner == domain_identifier)); // RQ5
      end
   endfunction

   // ************************************************************
   // requester domain and level
   // ************************************************************

   reg [`DID_W-1:0] dom;
   reg [1:0] dom_idx;
   reg dom_known;
   reg [1:0] lvl;

   always @* begin
      dom = master_domain_map[req_master*`DID_W +: `DID_W]; // RQ9
      dom_idx = dom[1:0];
      // identifiers past the domain count are never granted
      dom_known = (dom < `NUM_DOMAINS); // RQ9
      // security from the processor state signal for all masters
      lvl = access_level(req_priv, req_nonsecure_state,
                         master_no_ns_priv[req_master]); // RQ1 RQ10
   end

   // ************************************************************
   // memory target lookup
   // ************************************************************

   reg mem_hit;
   reg [`POLICY_W-1:0] mem_code;
   reg mem_sema_en;
   reg [`SEMA_W-1:0] mem_sema_idx;
   integer r;

   always @* begin
      mem_hit = 1'b0;
      mem_code = 3'h0;
      mem_sema_en = 1'b0;
      mem_sema_idx = 2'h0;
      // lowest numbered matching descriptor wins
      for (r = `NUM_REGIONS-1; r >= 0; r = r - 1) begin
         if (region_match(req_addr, region_start[r*`ADDR_W +: `ADDR_W],
                          region_end[r*`ADDR_W +: `ADDR_W], region_valid[r])) begin
            mem_hit = 1'b1;
            mem_code = policy_by_dir(req_write, region_rd_policy, region_wr_policy,
                                     r[1:0], dom_idx); // RQ8
            mem_sema_en = region_sema_en[r];
            mem_sema_idx = region_sema_sel[r*`SEMA_W +: `SEMA_W];
         end
      end
   end

   // ************************************************************
   // peripheral target lookup
   // ************************************************************

   reg [`POLICY_W-1:0] per_code;
   reg per_sema_en;
   reg [`SEMA_W-1:0] per_sema_idx;

   always @* begin
      per_code = policy_by_dir(req_write, periph_rd_policy, periph_wr_policy,
                               req_periph_index, dom_idx); // RQ8
      per_sema_en = periph_sema_en[req_periph_index];
      per_sema_idx = periph_sema_sel[req_periph_index*`SEMA_W +: `SEMA_W];
   end

   // ************************************************************
   // decision
   // ************************************************************

   reg hit;
   reg [`POLICY_W-1:0] code;
   reg sema_en;
   reg [`SEMA_W-1:0] sema_idx;
   reg sema_ok;
   reg allow;

   always @* begin
      // every peripheral has its own policy; memory needs a region
      hit = req_periph || mem_hit;
      code = req_periph ? per_code : mem_code;
      sema_en = req_periph ? per_sema_en : mem_sema_en;
      sema_idx = req_periph ? per_sema_idx : mem_sema_idx;
      sema_ok = sema_pass(sema_en, req_write, sema_locked[sema_idx],
                          sema_owner[sema_idx*`DID_W +: `DID_W], dom); // RQ5
      allow = hit && dom_known && level_ok(code, lvl) && sema_ok; // RQ1
   end

   // ************************************************************
   // forward to slave
   // ************************************************************

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fwd_valid <= 1'b0;
         fwd_addr <= 32'h0000_0000;
         fwd_write <= 1'b0;
         fwd_periph <= 1'b0;
         fwd_domain <= 4'h0;
      end else begin
         fwd_valid <= req_valid && allow; // RQ2
         // details follow every request, denied ones too
         if (req_valid) begin
            fwd_addr <= req_addr;
            fwd_write <= req_write;
            fwd_periph <= req_periph;
            fwd_domain <= dom;
         end
      end
   end

   // ************************************************************
   // response to master
   // ************************************************************

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resp_error <= 1'b0;
         resp_master <= 2'h0;
      end else begin
         resp_error <= req_valid && !allow; // RQ11
         if (req_valid) begin
            resp_master <= req_master;
         end
      end
   end

   // ************************************************************
   // error capture
   // ************************************************************

   reg err_take;

   always @* begin
      // new violation wins over clear; first error held until cleared
      err_take = req_valid && !allow &&
                 (!err_status[`ERR_VALID_BIT] || err_clear); // RQ2
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         err_status <= 4'h0;
         err_addr <= 32'h0000_0000;
         err_domain <= 4'h0;
         err_master <= 2'h0;
      end else if (err_take) begin
         err_status[`ERR_VALID_BIT] <= 1'b1; // RQ11
         err_status[`ERR_WRITE_BIT] <= req_write;
         err_status[`ERR_PRIV_BIT] <= req_priv;
         err_status[`ERR_SEC_BIT] <= !req_nonsecure_state;
         err_addr <= req_addr; // RQ11
         err_domain <= dom;
         err_master <= req_master;
      end else if (err_clear) begin
         err_status <= 4'h0;
      end
   end

endmodule

// File: tb/dac_ic_model.sv
// Purpose: interconnect model issuing one request per call
// Assumes: driven at the falling edge, held over one rising edge
// Notes: idle address inverted so no stale value lingers
`timescale 1ns/1ps
module dac_ic_model (
   // clock
   input wire clk,
   // request
   output reg req_valid = 1'h0,
   output reg [1:0] req_master = 2'h0,
   output reg [31:0] req_addr = 32'h0000_0000,
   output reg req_write = 1'h0,
   output reg req_priv = 1'h0,
   output reg req_nonsecure_state = 1'h0,
   output reg req_periph = 1'h0,
   output reg [1:0] req_periph_index = 2'h0
);
   task issue(input [1:0] m, input [31:0] a, input [3:0] f);
      begin
         @(negedge clk);
         req_valid = 1'h1;
         req_master = m;
         req_addr = a;
         {req_write, req_priv, req_nonsecure_state, req_periph} = f;
         req_periph_index = a[1:0];
         @(negedge clk);
         req_valid = 1'h0;
         req_addr = ~req_addr;
      end
   endtask
endmodule

// File: tb/dac_chk.sv
// Purpose: port checker for the domain access checker
// Assumes: one clock, async active-low reset
// Notes: bound to every instance
`timescale 1ns/1ps
module dac_chk (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // request
   input wire req_valid,
   input wire [1:0] req_master,
   input wire [31:0] req_addr,
   input wire req_write,
   input wire err_clear,
   input wire [15:0] master_domain_map,
   // answers
   input wire fwd_valid,
   input wire [31:0] fwd_addr,
   input wire fwd_write,
   input wire [3:0] fwd_domain,
   input wire resp_error,
   input wire [1:0] resp_master,
   input wire [3:0] err_status,
   input wire [31:0] err_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [3:0] dom = master_domain_map[req_master*4 +: 4];
   a_one_answer: assert property (req_valid |=> fwd_valid ^ resp_error)
      else $error("request without exactly one answer");
   a_idle_quiet: assert property (!req_valid |=> !fwd_valid && !resp_error)
      else $error("answer without request");
   a_fwd_addr: assert property (req_valid |=> fwd_addr == $past(req_addr))
      else $error("forwarded address wrong");
   a_fwd_dir: assert property (req_valid |=> fwd_write == $past(req_write))
      else $error("forwarded direction wrong");
   a_fwd_dom: assert property (req_valid |=> fwd_domain == $past(dom))
      else $error("forwarded domain wrong");
   a_high_dom: assert property (req_valid && dom[3:2] != 2'h0 |=> resp_error)
      else $error("unknown domain not refused");
   a_resp_who: assert property (req_valid |=> resp_master == $past(req_master))
      else $error("response master wrong");
   a_err_first: assert property (((req_valid && !err_status[0]) ##1 resp_error)
      |-> err_status[0] && err_addr == $past(req_addr))
      else $error("error not captured");
   a_err_keep: assert property (err_status[0] && !err_clear |=> $stable(err_addr))
      else $error("captured error overwritten");
   a_err_clear: assert property (err_clear && !req_valid |=> err_status == 4'h0)
      else $error("error not cleared");
endmodule
bind domain_access_checker dac_chk chk_u (.*);

// File: tb/domain_access_checker_test.sv
// Purpose: self-checking bench for the domain access checker
// Assumes: masters 0..3 bound to domains 0..3, region 0 at 0x1000
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module domain_access_checker_test;
   reg clk = 1'h0;
   reg reset_n = 1'h0;
   wire req_valid, req_write, req_priv, req_nonsecure_state, req_periph;
   wire [1:0] req_master, req_periph_index, resp_master, err_master;
   wire [31:0] req_addr, fwd_addr, err_addr;
   wire fwd_valid, fwd_write, fwd_periph, resp_error;
   wire [3:0] fwd_domain, err_status, err_domain;
   reg [15:0] master_domain_map = 16'h3210;
   reg [3:0] master_category = 4'h2, master_no_ns_priv = 4'h0, region_valid = 4'h1;
   reg [127:0] region_start = 128'h1000, region_end = 128'h1fff;
   reg [47:0] region_rd_policy = 48'h04cc, region_wr_policy = 48'h0004;
   reg [47:0] periph_rd_policy = 48'h0000, periph_wr_policy = 48'h0004;
   reg [3:0] region_sema_en = 4'h0, periph_sema_en = 4'h1, sema_locked = 4'h1;
   reg [7:0] region_sema_sel = 8'h00, periph_sema_sel = 8'h00;
   reg [15:0] sema_owner = 16'h0000;
   reg err_clear = 1'h0;
   integer n_mismatch = 0, total_checks = 0, cyc = 0;
   dac_ic_model ic_u (.*);
   domain_access_checker dut_u (.*);
   always #5 clk = ~clk;
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_mismatch);
         if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   task chk(input [8*10:1] s, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", s, e, g);
         end
      end
   endtask
   task go(input [1:0] m, input [31:0] a, input [3:0] f, input e);
      begin
         ic_u.issue(m, a, f);
         chk("fwd_valid", e, fwd_valid);
         chk("resp_error", !e, resp_error);
      end
   endtask
   task t_levels;
      begin
         go(1, 32'h0000_1000, 4'h4, 1);
         go(1, 32'h0000_1000, 4'h0, 0);
         go(2, 32'h0000_1004, 4'h6, 1);
         go(2, 32'h0000_1004, 4'h2, 0);
         master_no_ns_priv = 4'h4;
         go(2, 32'h0000_1004, 4'h6, 0);
         master_no_ns_priv = 4'h0;
         go(3, 32'h0000_1ffc, 4'h0, 1);
         master_domain_map = 16'h4210;
         go(3, 32'h0000_1ffc, 4'h4, 0);
         master_domain_map = 16'h3210;
         $display("levels done");
      end
   endtask
   task t_dir;
      begin
         go(0, 32'h0000_1008, 4'hc, 1);
         chk("fwd_write", 1, fwd_write);
         go(3, 32'h0000_1008, 4'hc, 0);
         go(0, 32'h0000_2000, 4'h4, 0);
         region_sema_en = 4'h1;
         region_sema_sel = 8'h01;
         go(0, 32'h0000_1008, 4'hc, 0);
         region_sema_en = 4'h0;
         $display("direction done");
      end
   endtask
   task t_sema;
      begin
         go(0, 32'h0000_0000, 4'hd, 1);
         chk("fwd_periph", 1, fwd_periph);
         go(0, 32'h0000_0000, 4'h5, 0);
         sema_owner = 16'h0001;
         go(0, 32'h0000_0000, 4'hd, 0);
         sema_owner = 16'h0000;
         $display("semaphore done");
      end
   endtask
   task t_err;
      begin
         err_clear = 1'h1;
         @(negedge clk);
         err_clear = 1'h0;
         chk("err_status", 0, err_status);
         go(3, 32'h0000_1234, 4'h6, 0);
         chk("err_addr", 32'h0000_1234, err_addr);
         chk("err_domain", 3, err_domain);
         chk("err_master", 3, err_master);
         chk("err_status", 5, err_status);
         go(2, 32'h0000_1abc, 4'ha, 0);
         chk("err_addr", 32'h0000_1234, err_addr);
         err_clear = 1'h1;
         go(1, 32'h0000_1ffc, 4'h0, 0);
         err_clear = 1'h0;
         chk("err_addr", 32'h0000_1ffc, err_addr);
         $display("error capture done");
      end
   endtask
   initial begin
      repeat (8) @(negedge clk);
      reset_n = 1'h1;
      t_levels;
      t_dir;
      t_sema;
      t_err;
      give_verdict;
   end
endmodule
